// *** shared/scan_pkg.sv ***
// constants, register map and state types of the scan acquisition controller
package scan_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  REG_CMD       = 8'h00;
  localparam logic [7:0]  REG_CFG       = 8'h04;
  localparam logic [7:0]  REG_INT_TIME  = 8'h08;
  localparam logic [7:0]  REG_BURST_N   = 8'h0C;
  localparam logic [7:0]  REG_SCAN_CNT  = 8'h10;
  localparam logic [7:0]  REG_FIFO_DATA = 8'h14;
  localparam logic [7:0]  REG_FIFO_STAT = 8'h18;
  localparam logic [7:0]  REG_GPIO_OUT  = 8'h1C;
  localparam logic [7:0]  REG_GPIO_IN   = 8'h20;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h24;
  localparam logic [7:0]  REG_IRQ_EN    = 8'h28;
  localparam logic [7:0]  REG_IRQ_CLR   = 8'h2C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_START    = 0;
  localparam int CMD_STOP     = 1;
  localparam int CMD_FLUSH    = 2;
  localparam int CFG_ILLUM_EN = 0;
  localparam int CFG_TRIG_EN  = 1;
  localparam int CFG_SLOPE    = 2;
  localparam int CFG_MODE_LSB = 4;
  localparam int IRQ_SCAN     = 0;
  localparam int IRQ_CYCLE    = 1;
  localparam int IRQ_OVF      = 2;
  localparam int IRQ_W        = 3;

  // ----------------------------------------------------------------
  // readout modes, cfg field code
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SINGLE_SCAN  = 3'h0;
  localparam logic [2:0] MODE_SINGLE_CYCLE = 3'h1;
  localparam logic [2:0] MODE_CONTINUOUS   = 3'h2;
  localparam logic [2:0] MODE_BURST        = 3'h3;
  localparam logic [2:0] MODE_SYNCED_CONT  = 3'h4;

  // ----------------------------------------------------------------
  // fifo and timing
  // ----------------------------------------------------------------
  localparam int FIFO_AW     = 12;   // 4 K word build
  localparam int FIFO_DW     = 16;
  localparam int FIFO_WORDS  = 4096;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int ILLUM_PULSE_NS  = 45000;
  localparam int ILLUM_PULSE_CYC = ILLUM_PULSE_NS / CLK_PERIOD_NS;
  localparam int ILLUM_CNT_W     = 13;
  localparam logic [31:0] INT_TIME_RST = 32'h0000_0400;
  localparam logic [15:0] BURST_N_RST  = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_TRIG, ST_DUMMY, ST_INTEG, ST_READ
  } scan_state_t;

endpackage

// *** shared/fifo_mem_if.sv ***
// write and read ports between the controller and its fifo memory
`timescale 1ns/1ps
interface fifo_mem_if;
  import scan_pkg::*;
  logic                   wr_en;
  logic [FIFO_AW-1:0]     wr_addr;
  logic [FIFO_DW-1:0]     wr_data;
  logic [FIFO_AW-1:0]     rd_addr;
  logic [FIFO_DW-1:0]     rd_data;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// *** design/spectral_fifo_mem.sv ***
// dual port spectral word memory with registered read data
`timescale 1ns/1ps
module spectral_fifo_mem
  import scan_pkg::*;
(
  input  wire logic  clock,
  fifo_mem_if.mem    port
);

  logic [FIFO_DW-1:0] mem_r [FIFO_WORDS];
  logic [FIFO_DW-1:0] rd_data_r;

  // no reset on the array so it maps onto block ram
  always_ff @(posedge clock) begin
    if (port.wr_en) begin
      mem_r[port.wr_addr] <= port.wr_data;
    end
    rd_data_r <= mem_r[port.rd_addr];
  end

  assign port.rd_data = rd_data_r;

endmodule // spectral_fifo_mem

// *** design/spectral_scan_acq_controller.sv ***
// scan sequencer, spectral fifo control, trigger, illumination and registers
`timescale 1ns/1ps
module spectral_scan_acq_controller
  import scan_pkg::*;
#(
  parameter int ILLUM_CYC = ILLUM_PULSE_CYC
)(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [ADDR_W-1:0]       addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [31:0]             rdata,
  output logic                         irq,
  output logic                         fe_scan_start,
  input  wire logic                    fe_word_valid,
  input  wire logic [FIFO_DW-1:0]      fe_word,
  input  wire logic                    scan_end_pulse,
  output logic      [2:0]              fe_gpio_out,
  input  wire logic [2:0]              fe_gpio_in,
  output logic      [1:0]              ext_gpio_out,
  input  wire logic [1:0]              ext_gpio_in,
  input  wire logic                    ext_scan_trigger_in,
  output logic                         illum_pulse_out_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    scan_state_t              st;
    logic [2:0]               mode;
    logic                     illum_en;
    logic                     trig_en;
    logic                     trig_slope;
    logic [31:0]              int_time;
    logic [31:0]              int_cnt;
    logic [15:0]              burst_n;
    logic [15:0]              scan_cnt;
    logic [ILLUM_CNT_W-1:0]   illum_cnt;
    logic                     trig_s1;
    logic                     trig_s2;
    logic                     trig_s3;
    logic [FIFO_AW:0]         wr_ptr;
    logic [FIFO_AW:0]         rd_ptr;
    logic [FIFO_DW-1:0]       wr_data;
    logic                     wr_en;
    logic [4:0]               gpio_out;
    logic [4:0]               gpio_in;
    logic [IRQ_W-1:0]         irq_stat;
    logic [IRQ_W-1:0]         irq_en;
    logic                     fe_start;
    logic [31:0]              rdata;
    logic                     rd_fifo;
    logic                     fifo_hit;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RST = '{
    st: ST_IDLE, mode: MODE_SINGLE_SCAN, int_time: INT_TIME_RST,
    burst_n: BURST_N_RST, trig_s1: 1'b1, trig_s2: 1'b1, trig_s3: 1'b1,
    default: '0};

  ctrl_state_t s_r;
  ctrl_state_t s_nxt;

  fifo_mem_if mem_bus ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [FIFO_AW:0] fifo_level(
    input logic [FIFO_AW:0] wp,
    input logic [FIFO_AW:0] rp);
    fifo_level = wp - rp;
  endfunction

  function automatic logic [ILLUM_CNT_W-1:0] illum_load(input logic en);
    illum_load = en ? ILLUM_CNT_W'(ILLUM_CYC) : '0;
  endfunction

  logic [FIFO_AW:0]   level;
  logic               fifo_empty;
  logic               fifo_full;
  logic               pop_ok;
  logic               trig_edge;
  logic               go;
  logic               last_scan;
  logic               cmd_wr;
  logic [IRQ_W-1:0]   ev;
  logic [IRQ_W-1:0]   clr;

  assign level      = fifo_level(s_r.wr_ptr, s_r.rd_ptr);
  assign fifo_empty = (level == '0);
  assign fifo_full  = level[FIFO_AW];
  assign pop_ok     = !fifo_empty && !(s_r.wr_en && level == 13'h0001);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.fe_start = 1'b0;
    s_nxt.wr_en    = 1'b0;
    s_nxt.rd_fifo  = 1'b0;
    s_nxt.fifo_hit = 1'b0;
    go             = 1'b0;
    last_scan      = 1'b0;
    ev             = '0;
    clr            = '0;
    cmd_wr         = wr_stb && (addr == REG_CMD);

    // first stage feeds only the second one
    s_nxt.trig_s1 = ext_scan_trigger_in;
    s_nxt.trig_s2 = s_r.trig_s1;
    s_nxt.trig_s3 = s_r.trig_s2;
    if (s_r.trig_slope) begin
      trig_edge = s_r.trig_s2 ^ s_r.trig_s3;
    end else begin
      trig_edge = s_r.trig_s3 & ~s_r.trig_s2;
    end

    s_nxt.gpio_in = {fe_gpio_in, ext_gpio_in};

    // one-shot, runs out independent of scan length
    if (s_r.illum_cnt != '0) begin
      s_nxt.illum_cnt = s_r.illum_cnt - 1'b1;
    end

    // spectral words into the fifo while reading out
    if (s_r.st == ST_READ && fe_word_valid) begin
      if (!fifo_full) begin
        s_nxt.wr_en   = 1'b1;
        s_nxt.wr_data = fe_word;
        s_nxt.wr_ptr  = s_r.wr_ptr + 1'b1;
      end else begin
        ev[IRQ_OVF] = 1'b1;
      end
    end

    case (s_r.st)
      ST_IDLE: begin
        if (cmd_wr && wdata[CMD_START]) begin
          s_nxt.scan_cnt = '0;
          if (s_r.trig_en) begin
            s_nxt.st = ST_WAIT_TRIG;
          end else begin
            go = 1'b1;
          end
        end
      end
      ST_WAIT_TRIG: begin
        // edges are only looked at here
        if (trig_edge) begin
          go = 1'b1;
        end
      end
      ST_DUMMY: begin
        if (scan_end_pulse) begin
          s_nxt.illum_cnt = illum_load(s_r.illum_en);
          s_nxt.int_cnt   = s_r.int_time;
          s_nxt.st        = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (s_r.int_cnt == '0) begin
          s_nxt.fe_start = 1'b1;
          s_nxt.st       = ST_READ;
        end else begin
          s_nxt.int_cnt = s_r.int_cnt - 1'b1;
        end
      end
      ST_READ: begin
        if (scan_end_pulse) begin
          s_nxt.scan_cnt = s_r.scan_cnt + 1'b1;
          ev[IRQ_SCAN]   = 1'b1;
          case (s_r.mode)
            MODE_SINGLE_SCAN:  last_scan = 1'b1;
            MODE_SINGLE_CYCLE: last_scan = 1'b1;
            MODE_BURST: begin
              last_scan = (s_r.scan_cnt + 1'b1) >= s_r.burst_n;
            end
            default: last_scan = 1'b0;
          endcase
          if (last_scan) begin
            s_nxt.st      = ST_IDLE;
            ev[IRQ_CYCLE] = 1'b1;
          end else if (s_r.trig_en && s_r.mode != MODE_SYNCED_CONT) begin
            s_nxt.st = ST_WAIT_TRIG;
          end else begin
            // readout end opens the next integration window
            s_nxt.illum_cnt = illum_load(s_r.illum_en);
            s_nxt.int_cnt   = s_r.int_time;
            s_nxt.st        = ST_INTEG;
          end
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase

    // single scan reads what integrated since the last readout
    if (go) begin
      s_nxt.fe_start = 1'b1;
      if (s_r.mode == MODE_SINGLE_SCAN) begin
        s_nxt.st = ST_READ;
      end else begin
        s_nxt.st = ST_DUMMY;
      end
    end

    if (cmd_wr && wdata[CMD_STOP]) begin
      s_nxt.st       = ST_IDLE;
      s_nxt.fe_start = 1'b0;
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    if (wr_stb) begin
      case (addr)
        REG_CFG: begin
          s_nxt.illum_en   = wdata[CFG_ILLUM_EN];
          s_nxt.trig_en    = wdata[CFG_TRIG_EN];
          s_nxt.trig_slope = wdata[CFG_SLOPE];
          s_nxt.mode       = wdata[CFG_MODE_LSB +: 3];
        end
        REG_INT_TIME: s_nxt.int_time = wdata;
        REG_BURST_N:  s_nxt.burst_n  = wdata[15:0];
        REG_GPIO_OUT: s_nxt.gpio_out = wdata[4:0];
        REG_IRQ_EN:   s_nxt.irq_en   = wdata[IRQ_W-1:0];
        REG_IRQ_CLR:  clr            = wdata[IRQ_W-1:0];
        default: ;
      endcase
    end

    // ----------------------------------------------------------------
    // register reads, data one cycle later
    // ----------------------------------------------------------------
    s_nxt.rdata = '0;
    if (rd_stb) begin
      case (addr)
        REG_CFG: begin
          s_nxt.rdata[CFG_ILLUM_EN]      = s_r.illum_en;
          s_nxt.rdata[CFG_TRIG_EN]       = s_r.trig_en;
          s_nxt.rdata[CFG_SLOPE]         = s_r.trig_slope;
          s_nxt.rdata[CFG_MODE_LSB +: 3] = s_r.mode;
        end
        REG_INT_TIME: s_nxt.rdata = s_r.int_time;
        REG_BURST_N:  s_nxt.rdata = {16'h0000, s_r.burst_n};
        REG_SCAN_CNT: s_nxt.rdata = {16'h0000, s_r.scan_cnt};
        REG_FIFO_STAT: begin
          s_nxt.rdata[FIFO_AW:0] = level;
          s_nxt.rdata[16]        = fifo_empty;
          s_nxt.rdata[17]        = fifo_full;
          s_nxt.rdata[18]        = (s_r.st != ST_IDLE);
          s_nxt.rdata[22:20]     = s_r.st;
        end
        REG_FIFO_DATA: begin
          // pop is allowed while acquisition keeps writing
          s_nxt.rd_fifo  = 1'b1;
          s_nxt.fifo_hit = pop_ok;
          if (pop_ok) begin
            s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
          end
        end
        REG_GPIO_OUT: s_nxt.rdata = {27'h0000000, s_r.gpio_out};
        REG_GPIO_IN:  s_nxt.rdata = {27'h0000000, s_r.gpio_in};
        REG_IRQ_STAT: s_nxt.rdata = {29'h00000000, s_r.irq_stat};
        REG_IRQ_EN:   s_nxt.rdata = {29'h00000000, s_r.irq_en};
        default: ;
      endcase
    end

    // flush drops stored words; a word written this cycle is lost too
    if (cmd_wr && wdata[CMD_FLUSH]) begin
      s_nxt.wr_ptr = '0;
      s_nxt.rd_ptr = '0;
      s_nxt.wr_en  = 1'b0;
    end

    // a new event beats a clear in the same cycle
    s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // fifo memory
  // ----------------------------------------------------------------
  // write lands one cycle after capture; a pop of that word waits a cycle
  assign mem_bus.wr_en   = s_r.wr_en;
  assign mem_bus.wr_addr = s_r.wr_ptr[FIFO_AW-1:0] - 1'b1;
  assign mem_bus.wr_data = s_r.wr_data;
  assign mem_bus.rd_addr = s_r.rd_ptr[FIFO_AW-1:0];

  spectral_fifo_mem u_mem (
    .clock (clock),
    .port  (mem_bus.mem)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    if (s_r.rd_fifo) begin
      rdata = s_r.fifo_hit ? {16'h0000, mem_bus.rd_data} : 32'h00000000;
    end else begin
      rdata = s_r.rdata;
    end
  end

  assign irq               = |(s_r.irq_stat & s_r.irq_en);
  assign fe_scan_start     = s_r.fe_start;
  assign ext_gpio_out      = s_r.gpio_out[1:0];
  assign fe_gpio_out       = s_r.gpio_out[4:2];
  assign illum_pulse_out_n = (s_r.illum_cnt == '0);

endmodule // spectral_scan_acq_controller

// *** verification/scan_acq_properties.sv ***
// port assertions of the scan acquisition controller
`timescale 1ns/1ps
module scan_acq_properties
  import scan_pkg::*;
#(
  parameter int ILLUM_CYC = ILLUM_PULSE_CYC
)(
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic [ADDR_W-1:0]   addr,
  input wire logic [31:0]         wdata,
  input wire logic                wr_stb,
  input wire logic                rd_stb,
  input wire logic [31:0]         rdata,
  input wire logic                irq,
  input wire logic                fe_scan_start,
  input wire logic                scan_end_pulse,
  input wire logic [2:0]          fe_gpio_out,
  input wire logic [1:0]          ext_gpio_out,
  input wire logic                illum_pulse_out_n
);
  import scan_pkg::*;
  // ----------------------------------------------------------------
  // shadow of host settings, low-time counter
  // ----------------------------------------------------------------
  logic        en_r;
  logic        trig_r;
  logic [15:0] lo_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      en_r   <= 1'b0;
      trig_r <= 1'b0;
      lo_r   <= 16'h0;
    end else begin
      if (wr_stb && addr == REG_CFG) begin
        en_r   <= wdata[CFG_ILLUM_EN];
        trig_r <= wdata[CFG_TRIG_EN];
      end
      lo_r <= illum_pulse_out_n ? 16'h0 : lo_r + 16'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence start_wr;
    wr_stb && addr == REG_CMD && wdata[CMD_START] && !trig_r;
  endsequence
  sequence gpio_wr;
    wr_stb && addr == REG_GPIO_OUT;
  endsequence
  sequence pulse_on;
    $fell(illum_pulse_out_n);
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  start_one_a: assert property (fe_scan_start |=> !fe_scan_start)
    else $error("scan start longer than one cycle");
  start_cmd_a: assert property (start_wr |=> fe_scan_start)
    else $error("host start gave no scan start");
  illum_lock_a: assert property (pulse_on |-> en_r)
    else $error("illumination pulse while locked");
  illum_start_a: assert property (pulse_on |-> $past(scan_end_pulse))
    else $error("illumination pulse not after scan end");
  illum_width_a: assert property
    ($rose(illum_pulse_out_n) |-> lo_r == ILLUM_CYC)
    else $error("illumination pulse width wrong");
  rdata_idle_a: assert property (!rd_stb |=> rdata == 32'h0)
    else $error("read data outside read cycle");
  irq_mask_a: assert property
    (wr_stb && addr == REG_IRQ_EN && wdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt high with all enables off");
  gpio_out_a: assert property (gpio_wr |=>
    fe_gpio_out == $past(wdata[4:2]) && ext_gpio_out == $past(wdata[1:0]))
    else $error("general outputs do not follow write");
endmodule // scan_acq_properties

bind spectral_scan_acq_controller scan_acq_properties #(
  .ILLUM_CYC(ILLUM_CYC)
) chk (
  .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
  .fe_scan_start(fe_scan_start), .scan_end_pulse(scan_end_pulse),
  .fe_gpio_out(fe_gpio_out), .ext_gpio_out(ext_gpio_out),
  .illum_pulse_out_n(illum_pulse_out_n)
);

// *** verification/front_end_model.sv ***
// behavioural front-end board: dummy or readout scan of three words
`timescale 1ns/1ps
module front_end_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        fe_scan_start,
  output logic             fe_word_valid,
  output logic [15:0]      fe_word,
  output logic             scan_end_pulse
);
  logic [3:0] cnt_r;
  logic       send;
  assign send = cnt_r >= 4'h4 && cnt_r <= 4'h6;
  // words repeat per scan; idle bus toggles so stale data never matches
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r          <= 4'h0;
      fe_word_valid  <= 1'b0;
      fe_word        <= 16'h0;
      scan_end_pulse <= 1'b0;
    end else begin
      fe_word_valid  <= send;
      fe_word        <= send ? 16'hA000 + 16'(cnt_r - 4'h4) : ~fe_word;
      scan_end_pulse <= cnt_r == 4'h7;
      if (cnt_r != 4'h0)
        cnt_r <= (cnt_r == 4'h7) ? 4'h0 : cnt_r + 4'h1;
      else if (fe_scan_start)
        cnt_r <= 4'h1;
    end
  end
endmodule // front_end_model

// *** verification/test_spectral_scan_acq_controller.sv ***
// self-checking bench for the scan acquisition controller
`timescale 1ns/1ps
module test_spectral_scan_acq_controller;
  import scan_pkg::*;
  localparam int ILLUM_T = 8;
  localparam int INT_T   = 20;
  logic        clock, rst_n, wr_stb, rd_stb, irq, fe_scan_start;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        fe_word_valid, scan_end_pulse, trig, illum_n;
  logic [15:0] fe_word;
  logic [2:0]  fe_gpio_out, fe_gpio_in;
  logic [1:0]  ext_gpio_out, ext_gpio_in;
  int          errors, checked, cyc, n;

  spectral_scan_acq_controller #(.ILLUM_CYC(ILLUM_T)) DUT (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq),
    .fe_scan_start(fe_scan_start), .fe_word_valid(fe_word_valid),
    .fe_word(fe_word), .scan_end_pulse(scan_end_pulse),
    .fe_gpio_out(fe_gpio_out), .fe_gpio_in(fe_gpio_in),
    .ext_gpio_out(ext_gpio_out), .ext_gpio_in(ext_gpio_in),
    .ext_scan_trigger_in(trig), .illum_pulse_out_n(illum_n));
  front_end_model fe (
    .clock(clock), .rst_n(rst_n), .fe_scan_start(fe_scan_start),
    .fe_word_valid(fe_word_valid), .fe_word(fe_word),
    .scan_end_pulse(scan_end_pulse));

  // ----------------------------------------------------------------
  // bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    @(negedge clock);
    chk(rdata, exp);
  endtask
  // waits on scan start (0) or scan end (1), bounded
  task automatic wait_for(input int s);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((s == 0 ? fe_scan_start : scan_end_pulse) !== 1'b1
               && n < 300);
    if (n >= 300) chk(n, 32'h0);
  endtask
  task automatic stop_test;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    rchk(REG_CFG, 32'h0);
    rchk(REG_INT_TIME, 32'h400);
    rchk(REG_BURST_N, 32'h1);
    rchk(REG_FIFO_STAT, 32'h0001_0000);
    rchk(8'h30, 32'h0);
  endtask
  task automatic t_gpio;
    wr(REG_GPIO_OUT, 32'h1D);
    @(negedge clock);
    chk({27'h0, fe_gpio_out, ext_gpio_out}, 32'h1D);
    @(posedge clock);
    fe_gpio_in  <= 3'h5;
    ext_gpio_in <= 2'h2;
    repeat (3) @(posedge clock);
    rchk(REG_GPIO_IN, 32'h16);
  endtask
  // one readout cycle; illumination enabled or locked
  task automatic t_cycle(input logic en);
    int lo;
    lo = 0;
    wr(REG_INT_TIME, INT_T);
    wr(REG_CFG, {25'h0, MODE_SINGLE_CYCLE, 3'h0, en});
    wr(REG_CMD, 32'h1);
    wait_for(0);
    chk(n, 1);
    wait_for(1);
    @(negedge clock);
    chk(illum_n, !en);
    for (int i = 1; i < INT_T + 2; i++) begin
      lo += !illum_n;
      @(negedge clock);
    end
    chk(lo, en ? ILLUM_T : 0);
    chk(fe_scan_start, 1'b1);
    wait_for(1);
    repeat (3) @(negedge clock);
    rchk(REG_FIFO_STAT, 32'h3);
    rchk(REG_IRQ_STAT, 32'h3);
    wr(REG_IRQ_EN, 32'h3);
    @(negedge clock);
    chk(irq, 1'b1);
    wr(REG_IRQ_CLR, 32'h3);
    @(negedge clock);
    chk(irq, 1'b0);
    for (int i = 0; i < 3; i++)
      rchk(REG_FIFO_DATA, 32'hA000 + i);
    rchk(REG_FIFO_DATA, 32'h0);
    wr(REG_IRQ_EN, 32'h0);
  endtask
  // drive trigger level, expect start or none
  task automatic trig_step(input logic lvl, input logic exp);
    int hits;
    hits = 0;
    @(posedge clock);
    trig <= lvl;
    repeat (8) begin
      @(negedge clock);
      hits += fe_scan_start;
    end
    chk(hits, exp);
    if (exp) begin
      wait_for(1);
      repeat (3) @(negedge clock);
    end
  endtask
  task automatic t_trigger;
    int hits;
    hits = 0;
    wr(REG_CFG, 32'h2);
    wr(REG_CMD, 32'h1);
    trig_step(1'b0, 1'b1);
    wr(REG_CMD, 32'h1);
    trig_step(1'b1, 1'b0);
    trig_step(1'b0, 1'b1);
    wr(REG_CFG, 32'h6);
    wr(REG_CMD, 32'h1);
    trig_step(1'b1, 1'b1);
    wr(REG_CMD, 32'h1);
    trig_step(1'b0, 1'b1);
    // second slope arrives while the started scan still reads out
    wr(REG_CMD, 32'h1);
    for (int i = 0; i < 16; i++) begin
      @(posedge clock);
      trig <= (i < 5);
      @(negedge clock);
      hits += fe_scan_start;
    end
    chk(hits, 1);
  endtask
  task automatic t_modes;
    wr(REG_BURST_N, 32'h2);
    for (int m = 2; m <= 4; m++) begin
      wr(REG_CMD, 32'h4);
      wr(REG_CFG, 32'(m) << CFG_MODE_LSB);
      wr(REG_CMD, 32'h1);
      repeat (150) @(negedge clock);
      rchk(REG_FIFO_DATA, 32'hA000);
      wr(REG_CMD, 32'h2);
      repeat (2) @(negedge clock);
      rchk(REG_FIFO_STAT, m == 3 ? 32'h5 : 32'hB);
    end
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test;
    end
  end
  initial begin
    errors = 0;
    checked = 0;
    cyc = 0;
    rst_n = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    fe_gpio_in = 3'h0;
    ext_gpio_in = 2'h0;
    trig = 1'b1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_defaults;
    t_gpio;
    t_cycle(1'b1);
    t_cycle(1'b0);
    t_trigger;
    t_modes;
    stop_test;
  end
endmodule // test_spectral_scan_acq_controller
